/* File: logic/dbd_pkg.sv */
// shared constants and types for the dual-bus / interleaved input demux
package dbd_pkg;

   // ----------------------------------------------------------------
   // widths and depths
   // ----------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int STAGE_N = 4;
   localparam int LVL_W = 5;

   // ----------------------------------------------------------------
   // register offsets (byte addresses) and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_BUS_INTERLEAVE_SELECT_BIT = 0;
   localparam int CTRL_MARKER_BIT = 1;
   localparam int CTRL_DUALCLK_BIT = 2;
   localparam int CTRL_SEL_LSB = 3;
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_PHASE_BIT = 1;
   localparam int STAT_LEVEL_LSB = 8;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [WORD_W-1:0] chan_a;
      logic [WORD_W-1:0] chan_b;
   } dbd_pair_t;

   typedef struct packed {
      logic [1:0] interp_sel;
      logic dual_clk;
      logic marker_sel;
      logic interleave;
   } dbd_cfg_t;

   typedef enum logic {DBD_PH_A, DBD_PH_B} dbd_phase_t;

endpackage : dbd_pkg

/* File: logic/dbd_fifo.sv */
// sample-pair fifo with a registered output stage
`timescale 1ns/1ps
module dbd_fifo
   import dbd_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [LVL_W-1:0] level_o
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic push;
   logic load;

   // ready is honest: only a free slot lets the source push
   assign in_ready_o = (level_o < LVL_W'(DEPTH));
   assign push = in_valid_i && in_ready_o;
   assign load = (level_o != '0) && (!out_valid_o || out_ready_i);

   // storage, no reset needed on the array
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level_o <= '0;
      end else begin
         if (push) begin
            wr_ptr <= PW'(wr_ptr + 1'b1);
         end
         if (load) begin
            rd_ptr <= PW'(rd_ptr + 1'b1);
         end
         level_o <= LVL_W'(level_o + LVL_W'(push) - LVL_W'(load));
      end
   end

   // output register keeps the top outputs on flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else if (load) begin
         out_valid_o <= 1'b1;
         out_data_o <= mem[rd_ptr];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end

endmodule : dbd_fifo

/* File: logic/dbd_stage_div.sv */
// power-of-two enable divider for the interpolation stages
`timescale 1ns/1ps
module dbd_stage_div
   import dbd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic [1:0] sel_i,
   output logic [STAGE_N-1:0] stage_en_o
);

   logic [STAGE_N-1:0] cnt;

   // low k+1 bits set: stage k fires at the base rate over 2^(k+1)
   function automatic logic [STAGE_N-1:0] dbd_ones(input int k);
      dbd_ones = STAGE_N'((1 << (k + 1)) - 1);
   endfunction : dbd_ones

   // free-running count, no phase strobe so devices may not align
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= '0;
      end else if (tick_i) begin
         cnt <= STAGE_N'(cnt + 1'b1);
      end
   end

   // only the first sel+1 stages run
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage_en_o <= '0;
      end else begin
         for (int k = 0; k < STAGE_N; k++) begin
            stage_en_o[k] <= tick_i && (k <= int'(sel_i)) && ((cnt & dbd_ones(k)) == dbd_ones(k));
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_stage_nest;
      @(posedge clk_i) disable iff (rst_i) stage_en_o[1] |-> stage_en_o[0];
   endproperty
   a_stage_nest: assert property (p_stage_nest) else $error("slower stage fired without faster one");

   property p_two_x_one;
      @(posedge clk_i) disable iff (rst_i) ($past(sel_i) == 2'h0) |-> (stage_en_o[3:1] == 3'h0);
   endproperty
   a_two_x_one: assert property (p_two_x_one) else $error("extra stage running at 2x");

   property p_half_rate;
      @(posedge clk_i) disable iff (rst_i) (stage_en_o[0] && tick_i) |=> !stage_en_o[0];
   endproperty
   a_half_rate: assert property (p_half_rate) else $error("first stage not at half rate");

endmodule : dbd_stage_div

/* File: logic/dbd_input_demux.sv */
// input bus capture, interleave demux and stage clocking for the converter
//
// What this block does
// - interleave bit low selects dual-bus mode
// - dual-bus: I on first, Q on second
// - interleave bit high: both words from first bus
// - interleaved words alternate into channels A, B
// - gate mode: first word after gate rise is A
// - then words alternate B, A per edge
// - marker mode: marker high means channel B
// - interleaved: first stage at half input rate
// - first-stage divider has no synchronization means
// - two-clock bit high selects dual-clock mode
// - dual-clock: stages run from sample-rate clock
// - stage k runs at sample clock over 2^(k+1)
// - 2x: one stage; 4x: half and quarter
`timescale 1ns/1ps
module dbd_input_demux
   import dbd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins from the baseband source
   input wire logic [WORD_W-1:0] first_input_bus_i,
   input wire logic [WORD_W-1:0] second_input_bus_i,
   input wire logic transmit_gate_i,
   input wire logic channel_marker_i,
   input wire logic low_rate_input_clock_i,
   input wire logic sample_rate_clock_in_i,
   // sample pairs towards the interpolation path
   output logic samp_valid_o,
   input wire logic samp_ready_i,
   output dbd_pair_t samp_o,
   output logic [STAGE_N-1:0] stage_en_o,
   output logic first_interp_stage_en_o
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   dbd_cfg_t cfg;
   logic ovf;
   dbd_phase_t phase;
   logic [WORD_W-1:0] a_s1, a_s2, b_s1, b_s2, hold_a;
   logic gate_s1, gate_s2, mark_s1, mark_s2;
   logic low_rate_input_clock_s1, low_rate_input_clock_s2, low_rate_input_clock_s3, sample_rate_clock_in_s1, sample_rate_clock_in_s2, sample_rate_clock_in_s3;
   logic gate_last;
   logic cap, gate_rise, base_tick;
   logic push_v, fifo_ready;
   dbd_pair_t push_d;
   logic [LVL_W-1:0] level;
   logic wb_req, wb_wr;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // two flops on every pin, a third on the clocks for edge detect; data and its clock see the same delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {a_s1, a_s2, b_s1, b_s2} <= '0;
         {gate_s1, gate_s2, mark_s1, mark_s2} <= 4'h0;
         {low_rate_input_clock_s1, low_rate_input_clock_s2, low_rate_input_clock_s3} <= 3'h0;
         {sample_rate_clock_in_s1, sample_rate_clock_in_s2, sample_rate_clock_in_s3} <= 3'h0;
      end else begin
         a_s1 <= first_input_bus_i;
         a_s2 <= a_s1;
         b_s1 <= second_input_bus_i;
         b_s2 <= b_s1;
         gate_s1 <= transmit_gate_i;
         gate_s2 <= gate_s1;
         mark_s1 <= channel_marker_i;
         mark_s2 <= mark_s1;
         low_rate_input_clock_s1 <= low_rate_input_clock_i;
         low_rate_input_clock_s2 <= low_rate_input_clock_s1;
         low_rate_input_clock_s3 <= low_rate_input_clock_s2;
         sample_rate_clock_in_s1 <= sample_rate_clock_in_i;
         sample_rate_clock_in_s2 <= sample_rate_clock_in_s1;
         sample_rate_clock_in_s3 <= sample_rate_clock_in_s2;
      end
   end

   // rising edges of the input clock mark a word; the pin clocks
   // must stay below half of clk_i to be seen at all
   assign cap = low_rate_input_clock_s2 && !low_rate_input_clock_s3;
   assign gate_rise = cap && gate_s2 && !gate_last;

   // gate seen high on a capture edge; any low spell clears it, so a
   // fall and rise between word edges still restarts at channel A
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_last <= 1'b0;
      end else if (!gate_s2) begin
         gate_last <= 1'b0;
      end else if (cap) begin
         gate_last <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // word steering
   // ----------------------------------------------------------------
   // builds one A/B pair per push; second bus ignored when interleaved
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase <= DBD_PH_A;
         hold_a <= '0;
         push_v <= 1'b0;
         push_d <= '0;
      end else begin
         push_v <= 1'b0;
         if (cap) begin
            if (!cfg.interleave) begin
               push_v <= 1'b1;
               push_d <= '{chan_a: a_s2, chan_b: b_s2};
               phase <= DBD_PH_A;
            end else if (cfg.marker_sel) begin
               if (mark_s2) begin
                  push_v <= 1'b1;
                  push_d <= '{chan_a: hold_a, chan_b: a_s2};
                  phase <= DBD_PH_A;
               end else begin
                  hold_a <= a_s2;
                  phase <= DBD_PH_B;
               end
            end else if (gate_s2) begin
               if (gate_rise || phase == DBD_PH_A) begin
                  hold_a <= a_s2;
                  phase <= DBD_PH_B;
               end else begin
                  push_v <= 1'b1;
                  push_d <= '{chan_a: hold_a, chan_b: a_s2};
                  phase <= DBD_PH_A;
               end
            end else begin
               // gate low: words are not taken, next rise restarts at A
               phase <= DBD_PH_A;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // fifo towards the interpolation path
   // ----------------------------------------------------------------
   // the pins cannot be stalled, so a full fifo drops and flags
   dbd_fifo #(
      .WIDTH($bits(dbd_pair_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(push_v),
      .in_ready_o(fifo_ready),
      .in_data_i(push_d),
      .out_valid_o(samp_valid_o),
      .out_ready_i(samp_ready_i),
      .out_data_o(samp_o),
      .level_o(level)
   );

   // ----------------------------------------------------------------
   // stage clocking
   // ----------------------------------------------------------------
   // dual-clock: sample-rate pin paces the stages; else clk_i stands in
   assign base_tick = cfg.dual_clk ? (sample_rate_clock_in_s2 && !sample_rate_clock_in_s3) : 1'b1;

   dbd_stage_div u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(base_tick),
      .sel_i(cfg.interp_sel),
      .stage_en_o(stage_en_o)
   );

   // first stage input: one pulse per pair, half the interleaved word
   // rate; the pair phase has no strobe to align several devices
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_interp_stage_en_o <= 1'b0;
      end else begin
         first_interp_stage_en_o <= cfg.interleave ? push_v : cap;
      end
   end

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   assign wb_req = wb_cyc_i && wb_stb_i;
   assign wb_wr = wb_req && wb_we_i && wb_ack_o;

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req && !wb_ack_o;
      end
   end

   // mode register; writes land on the edge that sees ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg <= dbd_cfg_t'(CTRL_RESET[$bits(dbd_cfg_t)-1:0]);
      end else if (wb_wr && wb_sel_i[0] && wb_adr_i[7:0] == ADDR_CTRL) begin
         cfg.interleave <= wb_dat_i[CTRL_BUS_INTERLEAVE_SELECT_BIT];
         cfg.marker_sel <= wb_dat_i[CTRL_MARKER_BIT];
         cfg.dual_clk <= wb_dat_i[CTRL_DUALCLK_BIT];
         cfg.interp_sel <= wb_dat_i[CTRL_SEL_LSB +: 2];
      end
   end

   // overflow is sticky, write one clears, a new drop wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovf <= 1'b0;
      end else if (push_v && !fifo_ready) begin
         ovf <= 1'b1;
      end else if (wb_wr && wb_sel_i[0] && wb_adr_i[7:0] == ADDR_STATUS && wb_dat_i[STAT_OVF_BIT]) begin
         ovf <= 1'b0;
      end
   end

   // read data loads on the edge that raises ack; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (wb_req && !wb_ack_o) begin
         wb_dat_o <= '0;
         unique case (wb_adr_i[7:0])
            ADDR_CTRL: wb_dat_o[CTRL_SEL_LSB+1:0] <= {cfg.interp_sel, cfg.dual_clk, cfg.marker_sel, cfg.interleave};
            ADDR_STATUS: begin
               wb_dat_o[STAT_OVF_BIT] <= ovf;
               wb_dat_o[STAT_PHASE_BIT] <= (phase == DBD_PH_B);
               wb_dat_o[STAT_LEVEL_LSB +: LVL_W] <= level;
            end
            default: wb_dat_o <= '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_dual_every_edge;
      @(posedge clk_i) disable iff (rst_i) (cap && !cfg.interleave) |=> push_v;
   endproperty
   a_dual_every_edge: assert property (p_dual_every_edge) else $error("dual-bus word not pushed");

   property p_dual_both;
      @(posedge clk_i) disable iff (rst_i)
         (cap && !cfg.interleave) |=> push_d.chan_a == $past(a_s2) && push_d.chan_b == $past(b_s2);
   endproperty
   a_dual_both: assert property (p_dual_both) else $error("dual-bus pair mismatched");

   property p_il_first_bus;
      @(posedge clk_i) disable iff (rst_i) (push_v && $past(cfg.interleave)) |-> push_d.chan_b == $past(a_s2);
   endproperty
   a_il_first_bus: assert property (p_il_first_bus) else $error("interleaved B not from first bus");

   property p_il_alternate;
      @(posedge clk_i) disable iff (rst_i)
         (push_v && $past(cfg.interleave) && !$past(cfg.marker_sel)) |-> phase == DBD_PH_A;
   endproperty
   a_il_alternate: assert property (p_il_alternate) else $error("phase not back to A after pair");

   property p_gate_first_a;
      @(posedge clk_i) disable iff (rst_i)
         (gate_rise && cfg.interleave && !cfg.marker_sel) |=> phase == DBD_PH_B && hold_a == $past(a_s2) && !push_v;
   endproperty
   a_gate_first_a: assert property (p_gate_first_a) else $error("word after gate rise not channel A");

   property p_b_then_a;
      @(posedge clk_i) disable iff (rst_i)
         (cap && cfg.interleave && !cfg.marker_sel && gate_s2 && !gate_rise && phase == DBD_PH_B)
         |=> push_v && phase == DBD_PH_A;
   endproperty
   a_b_then_a: assert property (p_b_then_a) else $error("channel B word not paired");

   property p_marker_b;
      @(posedge clk_i) disable iff (rst_i)
         (cap && cfg.interleave && cfg.marker_sel && mark_s2) |=> push_v && push_d.chan_b == $past(a_s2);
   endproperty
   a_marker_b: assert property (p_marker_b) else $error("marked word not channel B");

   property p_first_interp_stage_pair;
      @(posedge clk_i) disable iff (rst_i) (push_v && cfg.interleave) |=> first_interp_stage_en_o;
   endproperty
   a_first_interp_stage_pair: assert property (p_first_interp_stage_pair) else $error("first stage missed a pair");

   property p_dualclk_tick;
      @(posedge clk_i) disable iff (rst_i) (cfg.dual_clk && base_tick) |=> !base_tick || !cfg.dual_clk;
   endproperty
   a_dualclk_tick: assert property (p_dualclk_tick) else $error("stage tick not from sample clock");

   c_dual_push: cover property (@(posedge clk_i) disable iff (rst_i) cap && !cfg.interleave ##1 push_v);
   c_gate_pair: cover property (@(posedge clk_i) disable iff (rst_i) gate_rise ##[1:40] (push_v && cfg.interleave));
   c_marker_pair: cover property (@(posedge clk_i) disable iff (rst_i) cfg.marker_sel && push_v);
   c_overflow: cover property (@(posedge clk_i) disable iff (rst_i) push_v && !fifo_ready);

endmodule : dbd_input_demux

/* File: verif/dbd_src_model.sv */
// behavioural baseband source driving the converter's input pins
`timescale 1ns/1ps
module dbd_src_model
   import dbd_pkg::*;
(
   input wire logic clk_i,
   input wire logic smp_run_i,
   output logic [WORD_W-1:0] first_input_bus_o,
   output logic [WORD_W-1:0] second_input_bus_o,
   output logic transmit_gate_o,
   output logic channel_marker_o,
   output logic low_rate_input_clock_o,
   output logic sample_rate_clock_in_o
);
   logic [1:0] smp_cnt;

   // idle pins at time zero; the word clock stands low outside frames
   initial begin
      first_input_bus_o = '0;
      second_input_bus_o = '1;
      transmit_gate_o = 1'b0;
      channel_marker_o = 1'b0;
      low_rate_input_clock_o = 1'b0;
      sample_rate_clock_in_o = 1'b0;
      smp_cnt = '0;
   end

   // --------------------------------------------------------------
   // sample-rate clock, period of eight system cycles, only on demand
   // --------------------------------------------------------------
   always @(posedge clk_i) begin
      smp_cnt <= smp_run_i ? smp_cnt + 2'd1 : 2'd0;
      if (!smp_run_i) sample_rate_clock_in_o <= 1'b0;
      else if (smp_cnt == 2'd3) sample_rate_clock_in_o <= ~sample_rate_clock_in_o;
   end

   // one word: data, gate and marker settle four cycles before the clock rises
   task automatic send_word(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b, input logic gate,
                            input logic mk);
      @(posedge clk_i);
      first_input_bus_o <= a;
      second_input_bus_o <= b;
      transmit_gate_o <= gate;
      channel_marker_o <= mk;
      repeat (4) @(posedge clk_i);
      low_rate_input_clock_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      low_rate_input_clock_o <= 1'b0;
   endtask : send_word

   // released lines show the inverse, so stale data never looks valid
   task automatic release_bus();
      @(posedge clk_i);
      first_input_bus_o <= ~first_input_bus_o;
      second_input_bus_o <= ~second_input_bus_o;
      channel_marker_o <= ~channel_marker_o;
      transmit_gate_o <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask : release_bus
endmodule : dbd_src_model

/* File: verif/dbd_input_demux_tb_top.sv */
// self-checking bench for the input demux with a behavioural source
`timescale 1ns/1ps
module dbd_input_demux_tb_top import dbd_pkg::*;;
   typedef struct packed {
      logic [4:0] cfg;
      logic [3:0] mk;
      logic [3:0][WORD_W-1:0] w;
      dbd_pair_t e0;
      dbd_pair_t e1;
   } dbd_row_t;

   logic clk_i;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
   logic [31:0] wb_adr = '0, wb_wdat = '0, wb_rdat;
   logic [3:0] wb_sel = '0;
   logic [WORD_W-1:0] bus_a, bus_b;
   logic gate, marker, word_clk, smp_clk, fis_en, samp_valid;
   logic smp_run = 1'b0, samp_ready = 1'b0;
   logic [STAGE_N-1:0] stage_en;
   dbd_pair_t samp;
   dbd_pair_t got[$];
   dbd_row_t rows[4];
   int st_cnt[STAGE_N] = '{default: 0};
   int sd[STAGE_N];
   int fis_cnt = 0, fail_count = 0, n_checks = 0;

   dbd_src_model u_src (.clk_i(clk_i), .smp_run_i(smp_run), .first_input_bus_o(bus_a),
      .second_input_bus_o(bus_b), .transmit_gate_o(gate), .channel_marker_o(marker),
      .low_rate_input_clock_o(word_clk), .sample_rate_clock_in_o(smp_clk));

   dbd_input_demux dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .first_input_bus_i(bus_a), .second_input_bus_i(bus_b),
      .transmit_gate_i(gate), .channel_marker_i(marker), .low_rate_input_clock_i(word_clk),
      .sample_rate_clock_in_i(smp_clk), .samp_valid_o(samp_valid), .samp_ready_i(samp_ready),
      .samp_o(samp), .stage_en_o(stage_en), .first_interp_stage_en_o(fis_en));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // --------------------------------------------------------------
   // monitors and helpers
   // --------------------------------------------------------------
   // accepted pairs are queued; enables are counted for windowed checks
   always @(posedge clk_i) begin
      if (samp_valid === 1'b1 && samp_ready === 1'b1) got.push_back(samp);
      // counts move by nba so the main sequence reads them race-free
      for (int k = 0; k < STAGE_N; k++) if (stage_en[k] === 1'b1) st_cnt[k] <= st_cnt[k] + 1;
      if (fis_en === 1'b1) fis_cnt <= fis_cnt + 1;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // classic single cycle; ack is sampled at the edge, then released;
   // only the watchdog ends a wait for ack
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel, output logic [31:0] rd);
      @(posedge clk_i);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, we, 24'h0, adr, dat, sel};
      do begin
         @(posedge clk_i);
      end while (wb_ack !== 1'b1);
      rd = wb_rdat;
      {wb_cyc, wb_stb} <= 2'b00;
   endtask : wb_xfer

   task automatic wait_got(input int n);
      for (int i = 0; i < 200 && got.size() < n; i++) @(posedge clk_i);
      chk(32'(got.size()), 32'(n));
   endtask : wait_got

   // windowed count; the window is a multiple of every divider period
   task automatic count_stages(input int n);
      int s0[STAGE_N];
      repeat (16) @(posedge clk_i);
      s0 = st_cnt;
      repeat (n) @(posedge clk_i);
      for (int k = 0; k < STAGE_N; k++) sd[k] = st_cnt[k] - s0[k];
   endtask : count_stages

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize

   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      summarize();
   end

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin : main
      logic [31:0] rd;
      int f0;
      // dual-bus, gate, marker and stale-marker rows
      rows[0] = '{5'h00, 4'h0, {16'h4444, 16'h3333, 16'h2222, 16'h1111}, 32'h11112222, 32'h33334444};
      rows[1] = '{5'h09, 4'h0, {16'ha004, 16'ha003, 16'ha002, 16'ha001}, 32'ha001a002, 32'ha003a004};
      rows[2] = '{5'h03, 4'ha, {16'hb004, 16'hb003, 16'hb002, 16'hb001}, 32'hb001b002, 32'hb003b004};
      rows[3] = '{5'h03, 4'hc, {16'hc004, 16'hc003, 16'hc002, 16'hc001}, 32'hc002c003, 32'hc002c004};
      repeat (6) @(posedge clk_i);
      chk({25'h0, samp_valid, wb_ack, stage_en, fis_en}, 32'h0);
      rst_i <= 1'b0;
      wb_xfer(1'b0, ADDR_CTRL, 32'h0, 4'hf, rd);
      chk(rd, {24'h0, CTRL_RESET});
      wb_xfer(1'b1, 8'h08, 32'h1f, 4'hf, rd);
      wb_xfer(1'b1, ADDR_CTRL, 32'h1f, 4'h0, rd);
      wb_xfer(1'b0, 8'h08, 32'h0, 4'hf, rd);
      chk(rd, 32'h0);
      wb_xfer(1'b0, ADDR_CTRL, 32'h0, 4'hf, rd);
      chk(rd, 32'h0);
      samp_ready <= 1'b1;
      foreach (rows[r]) begin
         wb_xfer(1'b1, ADDR_CTRL, {27'h0, rows[r].cfg}, 4'h1, rd);
         f0 = fis_cnt;
         if (rows[r].cfg[CTRL_BUS_INTERLEAVE_SELECT_BIT]) begin
            for (int i = 0; i < 4; i++) u_src.send_word(rows[r].w[i], ~rows[r].w[i], 1'b1, rows[r].mk[i]);
         end else begin
            u_src.send_word(rows[r].w[0], rows[r].w[1], 1'b1, 1'b0);
            u_src.send_word(rows[r].w[2], rows[r].w[3], 1'b1, 1'b0);
         end
         u_src.release_bus();
         wait_got(2);
         chk(got.pop_front(), rows[r].e0);
         chk(got.pop_front(), rows[r].e1);
         chk(32'(fis_cnt - f0), 32'h2);
      end
      // gate low refuses words; an odd A at the gate's fall is dropped
      wb_xfer(1'b1, ADDR_CTRL, 32'h1, 4'h1, rd);
      u_src.send_word(16'hd000, 16'h0, 1'b0, 1'b0);
      for (int i = 1; i < 4; i++) u_src.send_word(16'hd000 + 16'(i), 16'h0, 1'b1, 1'b0);
      u_src.release_bus();
      wb_xfer(1'b0, ADDR_STATUS, 32'h0, 4'hf, rd);
      chk(rd & 32'h2, 32'h2);
      for (int i = 1; i < 3; i++) u_src.send_word(16'hd010 + 16'(i), 16'h0, 1'b1, 1'b0);
      u_src.release_bus();
      wait_got(2);
      chk(got.pop_front(), 32'hd001d002);
      chk(got.pop_front(), 32'hd011d012);
      // fill the fifo past full with the consumer stalled, then drain
      wb_xfer(1'b1, ADDR_CTRL, 32'h0, 4'h1, rd);
      samp_ready <= 1'b0;
      for (int i = 0; i < FIFO_DEPTH + 2; i++) u_src.send_word(16'(i), ~16'(i), 1'b1, 1'b0);
      u_src.release_bus();
      wb_xfer(1'b0, ADDR_STATUS, 32'h0, 4'hf, rd);
      chk(rd & 32'h1f01, 32'(FIFO_DEPTH << STAT_LEVEL_LSB) | 32'h1);
      samp_ready <= 1'b1;
      wait_got(FIFO_DEPTH + 1);
      for (int i = 0; i <= FIFO_DEPTH; i++) chk(got.pop_front(), {16'(i), ~16'(i)});
      wb_xfer(1'b1, ADDR_STATUS, 32'h1, 4'h1, rd);
      wb_xfer(1'b0, ADDR_STATUS, 32'h0, 4'hf, rd);
      chk(rd & 32'h1f01, 32'h0);
      // stage enables for every interpolation setting
      for (int s = 0; s < 4; s++) begin
         wb_xfer(1'b1, ADDR_CTRL, 32'(s << CTRL_SEL_LSB), 4'h1, rd);
         count_stages(32);
         for (int k = 0; k < STAGE_N; k++) chk(32'(sd[k]), k <= s ? 32'(32 >> (k + 1)) : 32'h0);
      end
      // dual clock: stages follow only the sample-rate clock
      wb_xfer(1'b1, ADDR_CTRL, 32'h4, 4'h1, rd);
      count_stages(32);
      chk(32'(sd[0]), 32'h0);
      smp_run <= 1'b1;
      count_stages(64);
      chk(32'(sd[0]), 32'h4);
      smp_run <= 1'b0;
      // reset in mid-run with a pair waiting at the output
      wb_xfer(1'b1, ADDR_CTRL, 32'h3, 4'h1, rd);
      samp_ready <= 1'b0;
      u_src.send_word(16'he001, 16'h0, 1'b1, 1'b0);
      u_src.send_word(16'he002, 16'h0, 1'b1, 1'b1);
      u_src.release_bus();
      chk({31'h0, samp_valid}, 32'h1);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, samp_valid}, 32'h0);
      wb_xfer(1'b0, ADDR_CTRL, 32'h0, 4'hf, rd);
      chk(rd, 32'h0);
      summarize();
   end
endmodule : dbd_input_demux_tb_top
